// ---- core/sync_serial_consts.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the serial port
// Assumes: 8-bit register bus, byte-wide registers
// Notes:   definitions only
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_MODE_CONTROL 8'ha0
`define OFS_PORT_STATUS 8'ha1
`define OFS_DATA_UPPER 8'ha2
`define OFS_DATA_LOWER 8'ha3
`define OFS_IRQ_STATUS 8'ha8
`define OFS_IRQ_MASK 8'ha9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MODE_OP_HI 7
`define MODE_OP_LO 6
`define MODE_CLK_SRC 3
`define STAT_FIXED_ONE 7
`define STAT_EXT_DATA 6
`define STAT_OVERRUN 5
`define STAT_START 0
`define IRQ_DONE 0
`define IRQ_OVERRUN 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_MODE_CONTROL 8'h00
`define RST_IRQ_MASK 2'h0
`define RST_SERIAL_CLK 1'b1

// ----------------------------------------------------------------
// timing: log2 of the half serial clock period, per divider code
// ----------------------------------------------------------------
`define HALF_LOG2_DIV1024 4'h9
`define HALF_LOG2_DIV256 4'h7
`define HALF_LOG2_DIV64 4'h5
`define HALF_LOG2_DIV32 4'h4
`define HALF_LOG2_DIV16 4'h3
`define HALF_LOG2_DIV8 4'h2
`define HALF_LOG2_DIV4 4'h1
`define HALF_LOG2_DIV2 4'h0
`define BITS_BYTE 5'h08
`define BITS_WORD 5'h10

`endif

// ---- core/sync_serial_pkg.sv ----
// Purpose: types shared by the serial port files
// Assumes: nothing
// Notes:   constants live in sync_serial_consts.svh
package sync_serial_pkg;
    typedef enum logic [1:0] {
        OP_BYTE = 2'b00,
        OP_WORD = 2'b01,
        OP_CONT = 2'b10,
        OP_RSVD = 2'b11
    } op_mode_e;

    // gray code along idle -> shift only; idle -> clock flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_CLOCK = 2'b11
    } xfer_state_e;
endpackage

// ---- core/serial_prescaler.sv ----
// Purpose: tick at every half period of the internal serial clock
// Assumes: clear pulses when a transfer starts, for a defined first edge
// Notes:   one tick per half period; division n gives a tick every n/2 cycles
`include "sync_serial_consts.svh"

module serial_prescaler #(
    parameter int CNT_W = 9
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic [2:0] div_sel,
    input wire logic clear,
    // result
    output logic tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;
    logic [3:0] half_log2;

    initial begin
        if (CNT_W < 9) $error("serial_prescaler: CNT_W below 9 cannot divide by 1024");
    end

    // divider code to half-period exponent
    always_comb begin
        unique case (div_sel)
            3'h0: half_log2 = `HALF_LOG2_DIV1024;
            3'h1: half_log2 = `HALF_LOG2_DIV256;
            3'h2: half_log2 = `HALF_LOG2_DIV64;
            3'h3: half_log2 = `HALF_LOG2_DIV32;
            3'h4: half_log2 = `HALF_LOG2_DIV16;
            3'h5: half_log2 = `HALF_LOG2_DIV8;
            3'h6: half_log2 = `HALF_LOG2_DIV4;
            3'h7: half_log2 = `HALF_LOG2_DIV2;
        endcase
        mask = CNT_W'((1 << half_log2) - 1);
        tick = ((cnt_q & mask) == mask);
    end

    // free-running count, restarted so the first half period is whole
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end
endmodule

// ---- core/level_edges.sv ----
// Purpose: rising and falling edge pulses of a synchronous level
// Assumes: the level is already synchronous to ref_clk
// Notes:   pulses are combinational, one cycle long
module level_edges (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // level watched
    input wire logic level,
    // edges
    output logic rise,
    output logic fall
);
    logic prev_q;

    // idle level of the serial clock is high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

// ---- core/sync_serial_port_one.sv ----
// Purpose: clocked synchronous serial channel, 8 or 16 bit, or continuous clock
// Assumes: all pin inputs synchronous to ref_clk; register bus strobes one cycle
// Notes:   data shift out lsb first on falling edges, sample on rising edges
//
// Summary of operation
// - prescaler divides by 1024 down to 2
// - internal source clocks transfers, drives clock pin
// - external source: clock pin is input, partner clocks
// - mode field: byte, word, continuous clock, reserved
// - external clock edge after completion sets overrun
// - overrun cleared only by zero after reading one
// - extended data bit reads data output level
// - writing extended data bit forces data output
// - upper data register is word high byte
// - upper data register unused in byte mode
// - lower data register is byte or low byte
//
// Our own choice: the address-and-strobe port.
`include "sync_serial_consts.svh"

module sync_serial_port_one #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // serial clock pin, two-way
    input wire logic serial_clock_pin_level,
    output logic serial_clock_pin_drive,
    output logic serial_clock_pin_oe,
    // serial data pins
    input wire logic serial_data_rx,
    output logic serial_data_out_pin,
    // interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] data_upper_q;
    logic [7:0] data_lower_q;
    logic so_q;
    logic overrun_q;
    logic overrun_seen_q;
    logic done_once_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [4:0] bit_cnt_q;
    logic sck_q;
    logic sck_oe_q;
    logic [7:0] rdata_q;
    logic irq_q;
    sync_serial_pkg::xfer_state_e state_q;
    sync_serial_pkg::xfer_state_e state_d;

    logic ext_clk;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic shift_edge;
    logic sample_edge;
    logic start_req;
    logic last_bit;
    logic xfer_done;
    logic overrun_set;
    logic [4:0] xfer_len;
    logic [7:0] status_val;
    logic wr_mode, wr_stat, wr_upper, wr_lower, wr_istat, wr_imask;
    sync_serial_pkg::op_mode_e op_mode;

    initial begin
        if (ADDR_W < 8) $error("sync_serial_port_one: ADDR_W below 8 cannot hold the map");
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // mode field and clock source straight from the mode register
    assign op_mode = sync_serial_pkg::op_mode_e'(mode_q[`MODE_OP_HI:`MODE_OP_LO]);
    assign ext_clk = mode_q[`MODE_CLK_SRC];
    assign xfer_len = (op_mode == sync_serial_pkg::OP_WORD) ? `BITS_WORD : `BITS_BYTE;

    assign wr_mode = reg_write && (reg_addr == ADDR_W'(`OFS_MODE_CONTROL));
    assign wr_stat = reg_write && (reg_addr == ADDR_W'(`OFS_PORT_STATUS));
    assign wr_upper = reg_write && (reg_addr == ADDR_W'(`OFS_DATA_UPPER));
    assign wr_lower = reg_write && (reg_addr == ADDR_W'(`OFS_DATA_LOWER));
    assign wr_istat = reg_write && (reg_addr == ADDR_W'(`OFS_IRQ_STATUS));
    assign wr_imask = reg_write && (reg_addr == ADDR_W'(`OFS_IRQ_MASK));

    // a start while busy or in the reserved mode is refused
    assign start_req = wr_stat && reg_wdata[`STAT_START] && (state_q == sync_serial_pkg::ST_IDLE)
        && (op_mode != sync_serial_pkg::OP_RSVD);

    // ----------------------------------------------------------------
    // clock sources
    // ----------------------------------------------------------------
    serial_prescaler #(
        .CNT_W(9)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .rst(rst),
        .div_sel(mode_q[2:0]),
        .clear(start_req),
        .tick(tick)
    );

    level_edges u_ext_edges (
        .ref_clk(ref_clk),
        .rst(rst),
        .level(serial_clock_pin_level),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // shift on falling, sample on rising, from whichever source is chosen
    always_comb begin
        if (ext_clk) begin
            shift_edge = ext_fall;
            sample_edge = ext_rise;
        end else begin
            shift_edge = tick && sck_q;
            sample_edge = tick && !sck_q;
        end
    end

    assign last_bit = (bit_cnt_q == xfer_len - 5'h01);
    assign xfer_done = (state_q == sync_serial_pkg::ST_SHIFT) && sample_edge && last_bit;

    // any partner clock edge once the word is complete is an overrun
    assign overrun_set = ext_clk && done_once_q && (state_q == sync_serial_pkg::ST_IDLE)
        && (ext_rise || ext_fall);

    // ----------------------------------------------------------------
    // transfer state
    // ----------------------------------------------------------------
    // next state; a start while busy is ignored
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sync_serial_pkg::ST_IDLE: begin
                if (start_req && op_mode == sync_serial_pkg::OP_CONT) begin
                    state_d = sync_serial_pkg::ST_CLOCK;
                end else if (start_req) begin
                    state_d = sync_serial_pkg::ST_SHIFT;
                end
            end
            sync_serial_pkg::ST_SHIFT: begin
                if (xfer_done) begin
                    state_d = sync_serial_pkg::ST_IDLE;
                end
            end
            sync_serial_pkg::ST_CLOCK: begin
                // the clock runs until software leaves continuous mode
                if (op_mode != sync_serial_pkg::OP_CONT) begin
                    state_d = sync_serial_pkg::ST_IDLE;
                end
            end
            default: state_d = sync_serial_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= sync_serial_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bit counter, counts sampled bits of the current word
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= 5'h00;
        end else if (start_req) begin
            bit_cnt_q <= 5'h00;
        end else if (state_q == sync_serial_pkg::ST_SHIFT && sample_edge) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // completed-word marker arms the overrun check until the next start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_once_q <= 1'b0;
        end else if (xfer_done) begin
            done_once_q <= 1'b1;
        end else if (start_req) begin
            done_once_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // serial clock pin
    // ----------------------------------------------------------------
    // idles high; toggles each half period only while the clock is needed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_q <= `RST_SERIAL_CLK;
        end else if (ext_clk || state_q == sync_serial_pkg::ST_IDLE) begin
            sck_q <= `RST_SERIAL_CLK;
        end else if (tick) begin
            sck_q <= !sck_q;
        end
    end

    // pin is driven only for the internal source
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_oe_q <= 1'b0;
        end else begin
            sck_oe_q <= !ext_clk;
        end
    end

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    // data output: software write wins over a shift in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            so_q <= 1'b0;
        end else if (wr_stat) begin
            so_q <= reg_wdata[`STAT_EXT_DATA];
        end else if (state_q == sync_serial_pkg::ST_SHIFT && shift_edge) begin
            so_q <= data_lower_q[0];
        end
    end

    // lower byte shifts alone in byte mode, below the upper in word mode;
    // software writes during a transfer are dropped so the word stays whole
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_lower_q <= 8'h00;
        end else if (state_q == sync_serial_pkg::ST_SHIFT) begin
            if (sample_edge && op_mode == sync_serial_pkg::OP_WORD) begin
                data_lower_q <= {data_upper_q[0], data_lower_q[7:1]};
            end else if (sample_edge) begin
                data_lower_q <= {serial_data_rx, data_lower_q[7:1]};
            end
        end else if (wr_lower) begin
            data_lower_q <= reg_wdata;
        end
    end

    // upper byte takes part only in word mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_upper_q <= 8'h00;
        end else if (state_q == sync_serial_pkg::ST_SHIFT) begin
            if (sample_edge && op_mode == sync_serial_pkg::OP_WORD) begin
                data_upper_q <= {serial_data_rx, data_upper_q[7:1]};
            end
        end else if (wr_upper) begin
            data_upper_q <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // control and status registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= `RST_MODE_CONTROL;
        end else if (wr_mode) begin
            mode_q <= reg_wdata;
        end
    end

    // remembers that software saw the overrun flag at one
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrun_seen_q <= 1'b0;
        end else if (reg_read && reg_addr == ADDR_W'(`OFS_PORT_STATUS) && overrun_q) begin
            overrun_seen_q <= 1'b1;
        end else if (!overrun_q) begin
            overrun_seen_q <= 1'b0;
        end
    end

    // set wins over the clear; writing one leaves it alone
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrun_q <= 1'b0;
        end else if (overrun_set) begin
            overrun_q <= 1'b1;
        end else if (wr_stat && !reg_wdata[`STAT_OVERRUN] && overrun_seen_q) begin
            overrun_q <= 1'b0;
        end
    end

    always_comb begin
        status_val = 8'h00;
        status_val[`STAT_FIXED_ONE] = 1'b1;
        status_val[`STAT_EXT_DATA] = so_q;
        status_val[`STAT_OVERRUN] = overrun_q;
        status_val[`STAT_START] = (state_q != sync_serial_pkg::ST_IDLE);
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // sticky events, write one to clear, a set in the same cycle wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q[`IRQ_DONE] <= xfer_done
                || (irq_stat_q[`IRQ_DONE] && !(wr_istat && reg_wdata[`IRQ_DONE]));
            irq_stat_q[`IRQ_OVERRUN] <= overrun_set
                || (irq_stat_q[`IRQ_OVERRUN] && !(wr_istat && reg_wdata[`IRQ_OVERRUN]));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= `RST_IRQ_MASK;
        end else if (wr_imask) begin
            irq_mask_q <= reg_wdata[1:0];
        end
    end

    // one cycle behind the status bits, so the pin comes from a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // read data, one cycle after the strobe, zero otherwise
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (!reg_read) begin
            rdata_q <= 8'h00;
        end else if (reg_addr == ADDR_W'(`OFS_MODE_CONTROL)) begin
            rdata_q <= mode_q;
        end else if (reg_addr == ADDR_W'(`OFS_PORT_STATUS)) begin
            rdata_q <= status_val;
        end else if (reg_addr == ADDR_W'(`OFS_DATA_UPPER)) begin
            rdata_q <= data_upper_q;
        end else if (reg_addr == ADDR_W'(`OFS_DATA_LOWER)) begin
            rdata_q <= data_lower_q;
        end else if (reg_addr == ADDR_W'(`OFS_IRQ_STATUS)) begin
            rdata_q <= {6'h00, irq_stat_q};
        end else if (reg_addr == ADDR_W'(`OFS_IRQ_MASK)) begin
            rdata_q <= {6'h00, irq_mask_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign serial_clock_pin_drive = sck_q;
    assign serial_clock_pin_oe = sck_oe_q;
    assign serial_data_out_pin = so_q;
    assign irq = irq_q;
endmodule

// ---- verification/serial_peer.sv ----
// Purpose: far-side serial peripheral, shifts a word against the port
// Assumes: lsb first, change on falling pin edge, sample on rising
// Notes:   pin idles high through a pull-up when nobody drives it
module serial_peer (
    // clock
    input wire logic ref_clk,
    // port side
    input wire logic drive,
    input wire logic oe,
    input wire logic data_out,
    // pins seen by the port
    output logic pin,
    output logic rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ext_clk = 1'b1;
    logic last = 1'b1;
    logic rx_q = 1'b1;
    logic [15:0] tx_w = 16'h0000;
    logic [3:0] n_fall = 4'h0;
    logic [3:0] n_base = 4'h0;
    logic [15:0] rx_word = 16'h0000;
    // pull-up level when the port does not drive
    assign pin = oe ? drive : ext_clk;
    assign rx = rx_q;
    // ---------------------------------
    // shift on pin edges
    // ---------------------------------
    always @(posedge ref_clk) begin
        last <= pin;
        if (last && !pin) begin
            rx_q <= tx_w[n_fall - n_base];
            n_fall <= n_fall + 4'h1;
        end
        if (!last && pin) begin
            rx_word <= {data_out, rx_word[15:1]};
        end
    end
    task automatic load(input logic [15:0] w);
        tx_w <= w;
        n_base <= n_fall;
    endtask
    // external shift clock
    task automatic pulse(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge ref_clk);
            ext_clk <= 1'b0;
            repeat (half) @(posedge ref_clk);
            ext_clk <= 1'b1;
        end
    endtask
endmodule

// ---- verification/sync_serial_port_one_chk.sv ----
// Purpose: port-level assertions of the serial port
// Assumes: register offsets a0 mode, a1 status, a9 irq mask
// Notes:   tracks mode and mask from bus writes
module sync_serial_port_one_chk #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic serial_clock_pin_level,
    input wire logic serial_clock_pin_drive,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_data_rx,
    input wire logic serial_data_out_pin,
    input wire logic irq
);
    logic [7:0] mode_q;
    logic [1:0] mask_q;
    logic stw_q;
    logic drv_q;
    logic armed_q;
    logic [9:0] cnt_q;
    logic [9:0] half;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ---------------------------------
    // shadow of mode and mask
    // ---------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= 8'h00;
            mask_q <= 2'h0;
            stw_q <= 1'b0;
        end else begin
            stw_q <= reg_write && reg_addr == 8'ha1;
            if (reg_write && reg_addr == 8'ha0) begin
                mode_q <= reg_wdata;
            end
            if (reg_write && reg_addr == 8'ha9) begin
                mask_q <= reg_wdata[1:0];
            end
        end
    end
    // half period counter; disarmed on mode and status writes, since a start restarts the prescaler
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drv_q <= 1'b1;
            armed_q <= 1'b0;
            cnt_q <= 10'h000;
        end else begin
            drv_q <= serial_clock_pin_drive;
            cnt_q <= (serial_clock_pin_drive != drv_q) ? 10'h000 : cnt_q + 10'h001;
            if (reg_write && (reg_addr == 8'ha0 || reg_addr == 8'ha1)) begin
                armed_q <= 1'b0;
            end else if (serial_clock_pin_drive != drv_q) begin
                armed_q <= 1'b1;
            end
        end
    end
    assign half = (mode_q[2:0] == 3'h0) ? 10'h200 :
        (mode_q[2:0] == 3'h1) ? 10'h080 : (10'h080 >> mode_q[2:0]);
    property p_half;
        serial_clock_pin_drive != drv_q && armed_q |-> cnt_q == half - 10'h001;
    endproperty
    a_half: assert property (p_half) else $error("serial clock half period wrong");
    property p_int_oe;
        (!mode_q[3])[*3] |-> serial_clock_pin_oe;
    endproperty
    a_int_oe: assert property (p_int_oe) else $error("clock pin not driven");
    property p_ext_oe;
        mode_q[3][*2] |-> !serial_clock_pin_oe;
    endproperty
    a_ext_oe: assert property (p_ext_oe) else $error("clock pin driven in external");
    property p_rsvd;
        (mode_q[7:6] == 2'b11)[*2] |-> $stable(serial_clock_pin_drive);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("clock moved in reserved mode");
    property p_ext_read;
        reg_read && reg_addr == 8'ha1 |=> reg_rdata[6] == $past(serial_data_out_pin);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("data bit read wrong");
    property p_ext_write;
        reg_write && reg_addr == 8'ha1 |=> serial_data_out_pin == $past(reg_wdata[6]);
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("data out not forced");
    property p_hold;
        $changed(serial_data_out_pin) && serial_clock_pin_oe |-> !serial_clock_pin_drive || stw_q;
    endproperty
    a_hold: assert property (p_hold) else $error("data out moved off falling edge");
    property p_irq_mask;
        (mask_q == 2'h0)[*2] |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq high while masked");
    c_irq: cover property (irq);
    c_ext: cover property (!serial_clock_pin_oe && !serial_clock_pin_level);
    c_word: cover property (mode_q[7:6] == 2'b01 && !serial_clock_pin_drive);
endmodule
bind sync_serial_port_one sync_serial_port_one_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- verification/test_sync_serial_port_one.sv ----
// Purpose: register-level tests of the serial port against a peer
// Assumes: 50 MHz clock, reset held 8 cycles
// Notes:   internal transfers use /8 and /4 so the peer keeps pace
module test_sync_serial_port_one;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic pin, drive, oe, rx, dout, irq;
    int err_total = 0;
    int n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    sync_serial_port_one dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .serial_clock_pin_level(pin), .serial_clock_pin_drive(drive),
        .serial_clock_pin_oe(oe), .serial_data_rx(rx), .serial_data_out_pin(dout), .irq(irq)
    );
    serial_peer peer (
        .ref_clk(ref_clk), .drive(drive), .oe(oe), .data_out(dout), .pin(pin), .rx(rx)
    );
    // ---------------------------------
    // bus tasks and checks
    // ---------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            reg_read <= 1'b1;
            reg_addr <= 8'ha1;
            @(posedge ref_clk);
            reg_read <= 1'b0;
            #1;
            if (reg_rdata[0] === 1'b0) return;
        end
        err_total++;
        $display("[FAIL] %0t transfer never ended", $time);
        stop_test();
    endtask
    task automatic start(input logic [7:0] m, input logic [7:0] u, input logic [7:0] l,
        input logic [15:0] w);
        wr(8'ha0, m);
        wr(8'ha2, u);
        wr(8'ha3, l);
        peer.load(w);
        wr(8'ha1, 8'h01);
    endtask
    // ---------------------------------
    // main sequence
    // ---------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rc(8'ha0, 8'h00);
        rc(8'ha1, 8'h80);
        rc(8'h55, 8'h00);
        chk(oe, 1'b1);
        start(8'h05, 8'h3c, 8'ha5, 16'h00c3);
        rc(8'ha1, 8'h81);
        wait_idle();
        rc(8'ha3, 8'hc3);
        rc(8'ha2, 8'h3c);
        chk(peer.rx_word[15:8], 8'ha5);
        chk(irq, 1'b0);
        wr(8'ha9, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        wr(8'ha8, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
        start(8'h46, 8'h12, 8'h34, 16'hbeef);
        wait_idle();
        rc(8'ha2, 8'hbe);
        rc(8'ha3, 8'hef);
        chk(peer.rx_word, 16'h1234);
        // continuous clock at every divider code, stopped high
        for (int c = 0; c < 8; c++) begin
            wr(8'ha0, {5'b10000, c[2:0]});
            wr(8'ha1, 8'h01);
            repeat (4 * (c == 0 ? 512 : c == 1 ? 128 : 128 >> c) - 4) @(posedge ref_clk);
            rc(8'ha1, 8'h81);
            wr(8'ha0, {5'b00000, c[2:0]});
            wait_idle();
        end
        wr(8'ha0, 8'hc5);
        wr(8'ha1, 8'h01);
        rc(8'ha1, 8'h80);
        wr(8'ha1, 8'h40);
        chk(dout, 1'b1);
        rc(8'ha1, 8'hc0);
        wr(8'ha1, 8'h00);
        chk(dout, 1'b0);
        rc(8'ha1, 8'h80);
        start(8'h08, 8'h00, 8'h81, 16'h005a);
        chk(oe, 1'b0);
        peer.pulse(8, 4);
        wait_idle();
        rc(8'ha3, 8'h5a);
        chk(peer.rx_word[15:8], 8'h81);
        rc(8'ha1, 8'hc0);
        peer.pulse(1, 4);
        rc(8'ha1, 8'he0);
        wr(8'ha1, 8'h60);
        rc(8'ha1, 8'he0);
        wr(8'ha1, 8'h40);
        rc(8'ha1, 8'hc0);
        rc(8'ha8, 8'h03);
        stop_test();
    end
endmodule
